// File: jofc_params.svh
// register offsets, field positions and reset values for the output format block
`ifndef JOFC_PARAMS_SVH
`define JOFC_PARAMS_SVH

`define JOFC_ADDR_W          16
`define JOFC_OFS_CB2_SEL     16'h055A
`define JOFC_OFS_SAMPLE_FMT  16'h0561
`define JOFC_OFS_CHAN_ORDER  16'h0564
`define JOFC_OFS_RATE_BAND   16'h056E
`define JOFC_OFS_PLL_STATUS  16'h056F
`define JOFC_OFS_QUICK_PARAM 16'h0570
`define JOFC_OFS_IRQ_STATUS  16'h0580
`define JOFC_OFS_IRQ_ENABLE  16'h0581
`define JOFC_OFS_IRQ_CLEAR   16'h0582

`define JOFC_RST_CB2_SEL     3'h1
`define JOFC_RST_INVERT      1'h0
`define JOFC_RST_FORMAT      2'h1
`define JOFC_RST_SWAP        1'h0
`define JOFC_RST_RATE_BAND   4'h0
`define JOFC_RST_QL          2'h1
`define JOFC_RST_QM          3'h1
`define JOFC_RST_QF          3'h1

`define JOFC_CB2_LOW         3'h0
`define JOFC_CB2_OVR         3'h1
`define JOFC_CB2_MONITOR     3'h2
`define JOFC_CB2_FAST        3'h3
`define JOFC_CB2_SYSREF      3'h5

`define JOFC_FMT_OFFSET_BIN  2'h0
`define JOFC_FMT_TWOS        2'h1

`define JOFC_BAND_LOW        4'h5
`define JOFC_BAND_MID        4'h1
`define JOFC_BAND_HIGH       4'h0
`define JOFC_BAND_TOP        4'h3

`define JOFC_IRQ_LOCK_BIT    0
`define JOFC_IRQ_UNLOCK_BIT  1
`define JOFC_IRQ_BAND_BIT    2

`endif

// File: jofc_pkg.sv
// types shared by the output format block
`default_nettype none
package jofc_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} jofc_bus_req_t;

	typedef struct packed {
		logic [2:0] lanes_log2;
		logic [2:0] conv_log2;
		logic [2:0] octets_log2;
		logic [4:0] lanes;
		logic [4:0] conv;
		logic [8:0] octets;
	} jofc_link_t;
endpackage
`default_nettype wire

// File: jofc_rx_model.sv
// receiver-side model that captures each formatted output word
`timescale 1ns/100ps
`default_nettype none
module jofc_rx_model #(
	parameter int SAMPLE_W = 14
) (
	input  wire logic                sys_clk, // device clock
	input  wire logic                rst_n,   // async reset, low
	input  wire logic [SAMPLE_W-1:0] samp_a,  // lane sample a
	input  wire logic [SAMPLE_W-1:0] samp_b,  // lane sample b
	input  wire logic                cbit2_a, // control bit a
	input  wire logic                cbit2_b, // control bit b
	output logic      [SAMPLE_W:0]   cap_a,   // captured word a
	output logic      [SAMPLE_W:0]   cap_b    // captured word b
);
	// one extra register stage, as a framer input flop would add
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_a <= '0;
			cap_b <= '0;
		end else begin
			cap_a <= {cbit2_a, samp_a};
			cap_b <= {cbit2_b, samp_b};
		end
	end
endmodule
`default_nettype wire

// File: jofc_top.sv
// register bank and sample formatting for the serial output path
//
// What this block does
// - control bit 2 source select; resets to overrange
// - invert flips samples; format offset binary or twos, default twos
// - channel swap bit zero keeps order, one swaps the channel pair
// - lane count is two to the L field, reset value one
// - converter count is two to the M field (zero for M above 4), reset value one
// - octets per frame is two to the F field, reset value one
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "jofc_params.svh"

module jofc_top #(
	parameter int SAMPLE_W = 14
) (
	input  wire logic                 sys_clk,      // 50 MHz clock
	input  wire logic                 rst_n,        // async reset, low
	input  wire jofc_pkg::jofc_bus_req_t bus_req,   // register request
	output logic [7:0]                rdata,        // read data, next cycle
	input  wire logic [SAMPLE_W-1:0]  samp_a_in,    // converter a sample
	input  wire logic [SAMPLE_W-1:0]  samp_b_in,    // converter b sample
	input  wire logic                 ovr_a,        // overrange, channel a
	input  wire logic                 ovr_b,        // overrange, channel b
	input  wire logic                 signal_monitor_flag, // monitor flag
	input  wire logic                 fast_detect_a, // fast detect_flag a
	input  wire logic                 fast_detect_b, // fast detect_flag b
	input  wire logic                 sysref_in,    // sysref sampled level
	input  wire logic                 pll_locked,   // serializer pll lock
	output logic [SAMPLE_W-1:0]       samp_a_out,   // formatted sample a
	output logic [SAMPLE_W-1:0]       samp_b_out,   // formatted sample b
	output logic                      cbit2_a,      // control bit 2, a
	output logic                      cbit2_b,      // control bit 2, b
	output logic [3:0]                rate_band,    // serializer rate band
	output jofc_pkg::jofc_link_t      link_cfg,     // L, M, F to framer
	output logic                      irq           // level interrupt
);
	import jofc_pkg::*;

	logic [2:0] cb2_sel_r;
	logic       invert_r;
	logic [1:0] format_r;
	logic       swap_r;
	logic       chan_rsvd_r;
	logic [3:0] band_r;
	logic [1:0] ql_r;
	logic [2:0] qm_r;
	logic [2:0] qf_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_en_r;
	logic       lock_d_r;
	logic [7:0] rdata_nxt;
	logic [2:0] irq_stat_nxt;

	wire hit_cb2   = bus_req.addr == `JOFC_OFS_CB2_SEL;
	wire hit_fmt   = bus_req.addr == `JOFC_OFS_SAMPLE_FMT;
	wire hit_chan  = bus_req.addr == `JOFC_OFS_CHAN_ORDER;
	wire hit_band  = bus_req.addr == `JOFC_OFS_RATE_BAND;
	wire hit_pll   = bus_req.addr == `JOFC_OFS_PLL_STATUS;
	wire hit_quick = bus_req.addr == `JOFC_OFS_QUICK_PARAM;
	wire hit_ist   = bus_req.addr == `JOFC_OFS_IRQ_STATUS;
	wire hit_ien   = bus_req.addr == `JOFC_OFS_IRQ_ENABLE;
	wire hit_iclr  = bus_req.addr == `JOFC_OFS_IRQ_CLEAR;
	wire wr        = bus_req.wr;

	// reserved codes have no source and read as a low bit
	function automatic logic cb2_pick(input logic [2:0] sel,
	                                  input logic ovr, input logic fast);
		case (sel)
			`JOFC_CB2_LOW:    cb2_pick = 1'b0;
			`JOFC_CB2_OVR:    cb2_pick = ovr;
			`JOFC_CB2_MONITOR: cb2_pick = signal_monitor_flag;
			`JOFC_CB2_FAST:   cb2_pick = fast;
			`JOFC_CB2_SYSREF: cb2_pick = sysref_in;
			default:          cb2_pick = 1'b0;
		endcase
	endfunction

	// twos complement flips the msb of an offset binary code
	function automatic logic [SAMPLE_W-1:0] fmt(input logic [SAMPLE_W-1:0] s);
		logic [SAMPLE_W-1:0] v;
		v = invert_r ? ~s : s;
		if (format_r == `JOFC_FMT_TWOS)
			v[SAMPLE_W-1] = ~v[SAMPLE_W-1];
		fmt = v;
	endfunction

	wire [SAMPLE_W-1:0] src_a = swap_r ? samp_b_in : samp_a_in;
	wire [SAMPLE_W-1:0] src_b = swap_r ? samp_a_in : samp_b_in;
	wire ovr_sa = swap_r ? ovr_b : ovr_a;
	wire ovr_sb = swap_r ? ovr_a : ovr_b;
	wire fast_sa = swap_r ? fast_detect_b : fast_detect_a;
	wire fast_sb = swap_r ? fast_detect_a : fast_detect_b;

	// events: lock gained, lock lost, rate band rewritten while locked
	wire ev_lock   = pll_locked & ~lock_d_r;
	wire ev_unlock = ~pll_locked & lock_d_r;
	wire ev_band   = wr & hit_band & pll_locked;
	wire [2:0] ev  = {ev_band, ev_unlock, ev_lock};
	wire [2:0] clr = (wr & hit_iclr) ? bus_req.wdata[2:0] : 3'h0;

	always_comb begin
		irq_stat_nxt = (irq_stat_r & ~clr) | ev; // set wins over clear
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (bus_req.rd) begin
			unique case (1'b1)
				hit_cb2:   rdata_nxt = {5'h00, cb2_sel_r};
				hit_fmt:   rdata_nxt = {5'h00, invert_r, format_r};
				hit_chan:  rdata_nxt = {6'h00, chan_rsvd_r, swap_r};
				hit_band:  rdata_nxt = {band_r, 4'h0};
				hit_pll:   rdata_nxt = {pll_locked, 7'h00};
				hit_quick: rdata_nxt = {ql_r, qm_r, qf_r};
				hit_ist:   rdata_nxt = {5'h00, irq_stat_r};
				hit_ien:   rdata_nxt = {5'h00, irq_en_r};
				default:   rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cb2_sel_r <= `JOFC_RST_CB2_SEL;
			invert_r  <= `JOFC_RST_INVERT;
			format_r  <= `JOFC_RST_FORMAT;
		end else if (wr && hit_cb2) begin
			cb2_sel_r <= bus_req.wdata[2:0];
		end else if (wr && hit_fmt) begin
			invert_r  <= bus_req.wdata[2];
			format_r  <= bus_req.wdata[1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			swap_r      <= `JOFC_RST_SWAP;
			chan_rsvd_r <= 1'b0;
			band_r      <= `JOFC_RST_RATE_BAND;
		end else if (wr && hit_chan) begin
			swap_r      <= bus_req.wdata[0];
			chan_rsvd_r <= bus_req.wdata[1];
		end else if (wr && hit_band) begin
			band_r      <= bus_req.wdata[7:4];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ql_r <= `JOFC_RST_QL;
			qm_r <= `JOFC_RST_QM;
			qf_r <= `JOFC_RST_QF;
		end else if (wr && hit_quick) begin
			ql_r <= bus_req.wdata[7:6];
			qm_r <= bus_req.wdata[5:3];
			qf_r <= bus_req.wdata[2:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= 3'h0;
			irq_en_r   <= 3'h0;
			lock_d_r   <= 1'b0;
			rdata      <= 8'h00;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			if (wr && hit_ien)
				irq_en_r <= bus_req.wdata[2:0];
			lock_d_r   <= pll_locked;
			rdata      <= rdata_nxt;
		end
	end

	// data path is registered so the framer sees glitch-free samples
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_a_out <= '0;
			samp_b_out <= '0;
			cbit2_a    <= 1'b0;
			cbit2_b    <= 1'b0;
		end else begin
			samp_a_out <= fmt(src_a);
			samp_b_out <= fmt(src_b);
			cbit2_a    <= cb2_pick(cb2_sel_r, ovr_sa, fast_sa);
			cbit2_b    <= cb2_pick(cb2_sel_r, ovr_sb, fast_sb);
		end
	end

	// codes above the documented range are passed on unchecked
	assign rate_band            = band_r;
	assign link_cfg.lanes_log2  = {1'b0, ql_r};
	assign link_cfg.conv_log2   = qm_r;
	assign link_cfg.octets_log2 = qf_r;
	assign link_cfg.lanes  = 5'(5'h01 << ql_r);
	assign link_cfg.conv   = 5'(5'h01 << qm_r);
	assign link_cfg.octets = 9'(9'h001 << qf_r);
	assign irq = |(irq_stat_r & irq_en_r);

	sequence s_cb2_write;
		wr && hit_cb2;
	endsequence

	property p_cb2_store;
		@(posedge sys_clk) disable iff (!rst_n)
		s_cb2_write |=> cb2_sel_r == $past(bus_req.wdata[2:0]);
	endproperty
	a_cb2_store: assert property (p_cb2_store)
		else $error("control bit 2 select not stored");

	property p_cb2_low;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r == `JOFC_CB2_LOW && !(wr && hit_cb2) |=> !cbit2_a && !cbit2_b;
	endproperty
	a_cb2_low: assert property (p_cb2_low)
		else $error("tie low select gave a high control bit");

	property p_cb2_ovr;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r == `JOFC_CB2_OVR && !swap_r |=> cbit2_a == $past(ovr_a);
	endproperty
	a_cb2_ovr: assert property (p_cb2_ovr)
		else $error("overrange not routed to control bit 2");

	property p_invert;
		@(posedge sys_clk) disable iff (!rst_n)
		invert_r && format_r == `JOFC_FMT_OFFSET_BIN && !swap_r
		|=> samp_a_out == ~$past(samp_a_in);
	endproperty
	a_invert: assert property (p_invert)
		else $error("sample inversion wrong");

	property p_twos;
		@(posedge sys_clk) disable iff (!rst_n)
		!invert_r && format_r == `JOFC_FMT_TWOS && !swap_r
		|=> samp_a_out[SAMPLE_W-1] != $past(samp_a_in[SAMPLE_W-1]);
	endproperty
	a_twos: assert property (p_twos)
		else $error("twos complement msb not flipped");

	property p_swap;
		@(posedge sys_clk) disable iff (!rst_n)
		swap_r && !invert_r && format_r == `JOFC_FMT_OFFSET_BIN
		|=> samp_a_out == $past(samp_b_in) && samp_b_out == $past(samp_a_in);
	endproperty
	a_swap: assert property (p_swap)
		else $error("channel swap not applied");

	property p_lanes;
		@(posedge sys_clk) disable iff (!rst_n)
		wr && hit_quick |=> link_cfg.lanes == (5'h01 << $past(bus_req.wdata[7:6]));
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("lane count mismatch");

	property p_conv;
		@(posedge sys_clk) disable iff (!rst_n)
		wr && hit_quick |=> link_cfg.conv == (5'h01 << $past(bus_req.wdata[5:3]));
	endproperty
	a_conv: assert property (p_conv)
		else $error("converter count mismatch");

	property p_octets;
		@(posedge sys_clk) disable iff (!rst_n)
		wr && hit_quick |=> link_cfg.octets == (9'h001 << $past(bus_req.wdata[2:0]));
	endproperty
	a_octets: assert property (p_octets)
		else $error("octet count mismatch");

	property p_lock_read;
		@(posedge sys_clk) disable iff (!rst_n)
		bus_req.rd && hit_pll |=> rdata == {$past(pll_locked), 7'h00};
	endproperty
	a_lock_read: assert property (p_lock_read)
		else $error("pll lock status readback wrong");

	sequence s_fmt_write;
		wr && hit_fmt;
	endsequence

	sequence s_chan_write;
		wr && hit_chan;
	endsequence

	property p_fmt_store;
		@(posedge sys_clk) disable iff (!rst_n)
		s_fmt_write |=> invert_r == $past(bus_req.wdata[2])
			&& format_r == $past(bus_req.wdata[1:0]);
	endproperty
	a_fmt_store: assert property (p_fmt_store)
		else $error("sample format not stored");

	property p_swap_store;
		@(posedge sys_clk) disable iff (!rst_n)
		s_chan_write |=> swap_r == $past(bus_req.wdata[0]);
	endproperty
	a_swap_store: assert property (p_swap_store)
		else $error("channel swap bit not stored");

	property p_no_swap;
		@(posedge sys_clk) disable iff (!rst_n)
		!swap_r && !invert_r && format_r == `JOFC_FMT_OFFSET_BIN
		|=> samp_a_out == $past(samp_a_in) && samp_b_out == $past(samp_b_in);
	endproperty
	a_no_swap: assert property (p_no_swap)
		else $error("normal channel order not kept");

	property p_cb2_ovr_swap;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r == `JOFC_CB2_OVR && swap_r
		|=> cbit2_a == $past(ovr_b) && cbit2_b == $past(ovr_a);
	endproperty
	a_cb2_ovr_swap: assert property (p_cb2_ovr_swap)
		else $error("swapped overrange not routed to control bit 2");

	property p_cb2_monitor;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r == `JOFC_CB2_MONITOR
		|=> cbit2_a == $past(signal_monitor_flag)
			&& cbit2_b == $past(signal_monitor_flag);
	endproperty
	a_cb2_monitor: assert property (p_cb2_monitor)
		else $error("monitor flag not routed to control bit 2");

	property p_cb2_fast;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r == `JOFC_CB2_FAST && !swap_r
		|=> cbit2_a == $past(fast_detect_a) && cbit2_b == $past(fast_detect_b);
	endproperty
	a_cb2_fast: assert property (p_cb2_fast)
		else $error("fast detect not routed to control bit 2");

	property p_cb2_sysref;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r == `JOFC_CB2_SYSREF
		|=> cbit2_a == $past(sysref_in) && cbit2_b == $past(sysref_in);
	endproperty
	a_cb2_sysref: assert property (p_cb2_sysref)
		else $error("sysref not routed to control bit 2");

	property p_cb2_rsvd;
		@(posedge sys_clk) disable iff (!rst_n)
		cb2_sel_r[2] && cb2_sel_r != `JOFC_CB2_SYSREF
		|=> !cbit2_a && !cbit2_b;
	endproperty
	a_cb2_rsvd: assert property (p_cb2_rsvd)
		else $error("reserved select gave a high control bit");

	property p_lock_event;
		@(posedge sys_clk) disable iff (!rst_n)
		pll_locked && !lock_d_r |=> irq_stat_r[`JOFC_IRQ_LOCK_BIT];
	endproperty
	a_lock_event: assert property (p_lock_event)
		else $error("lock gained not flagged in status");
endmodule
`default_nettype wire

// File: test_jofc_top.sv
// self-checking bench for the output format register bank
`timescale 1ns/100ps
`default_nettype none
`include "jofc_params.svh"
module test_jofc_top;
	import jofc_pkg::*;
	localparam int SW = 14;
	localparam int TEST_CYCLES = 4000;
	logic          sys_clk, rst_n, irq, cb_a, cb_b, lock;
	logic          ovr_a, ovr_b, mon_flag, fast_a, fast_b, sref;
	jofc_bus_req_t bus_req;
	jofc_link_t    link_cfg;
	logic [7:0]    rdata;
	logic [3:0]    band;
	logic [SW-1:0] sa, sb, oa, ob;
	logic [SW:0]   cap_a, cap_b;
	int            miscompares, comparisons;
	logic [3:0]    codes [4] = '{4'h5, 4'h1, 4'h0, 4'h3};

	jofc_top #(.SAMPLE_W(SW)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus_req(bus_req), .rdata(rdata), .samp_a_in(sa), .samp_b_in(sb),
		.ovr_a(ovr_a), .ovr_b(ovr_b), .signal_monitor_flag(mon_flag),
		.fast_detect_a(fast_a), .fast_detect_b(fast_b), .sysref_in(sref),
		.pll_locked(lock), .samp_a_out(oa), .samp_b_out(ob), .cbit2_a(cb_a),
		.cbit2_b(cb_b), .rate_band(band), .link_cfg(link_cfg), .irq(irq));
	jofc_rx_model #(.SAMPLE_W(SW)) rx (.sys_clk(sys_clk), .rst_n(rst_n),
		.samp_a(oa), .samp_b(ob), .cbit2_a(cb_a), .cbit2_b(cb_b),
		.cap_a(cap_a), .cap_b(cap_b));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	function automatic logic cbx(input logic [2:0] c, input logic [3:0] f);
		case (c)
			`JOFC_CB2_OVR:    return f[3];
			`JOFC_CB2_MONITOR: return f[2];
			`JOFC_CB2_FAST:   return f[1];
			`JOFC_CB2_SYSREF: return f[0];
			default:          return 1'b0;
		endcase
	endfunction
	function automatic logic [SW-1:0] fmx(input logic [SW-1:0] s,
		input logic inv, input logic [1:0] f);
		logic [SW-1:0] v;
		v = inv ? ~s : s;
		if (f == `JOFC_FMT_TWOS) v[SW-1] = ~v[SW-1];
		return v;
	endfunction
	// swap moves the per-channel flags with the samples
	task automatic step(input logic [2:0] c, input logic inv,
		input logic [1:0] f, input logic sw);
		logic [SW-1:0] ra, rb;
		logic [5:0]    fl;
		logic [3:0]    fa, fb;
		ra = SW'($urandom);
		rb = SW'($urandom);
		fl = 6'($urandom);
		fa = sw ? {fl[4], fl[3], fl[1], fl[0]} : {fl[5], fl[3], fl[2], fl[0]};
		fb = sw ? {fl[5], fl[3], fl[2], fl[0]} : {fl[4], fl[3], fl[1], fl[0]};
		@(posedge sys_clk);
		sa <= ra;
		sb <= rb;
		{ovr_a, ovr_b, mon_flag, fast_a, fast_b, sref} <= fl;
		repeat (2) @(posedge sys_clk);
		#1 chk(cap_a, {cbx(c, fa), fmx(sw ? rb : ra, inv, f)});
		chk(cap_b, {cbx(c, fb), fmx(sw ? ra : rb, inv, f)});
	endtask
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#(TEST_CYCLES * 20);
		miscompares++;
		complete_run();
	end
	initial begin
		logic [1:0] l, f;
		logic [2:0] m;
		rst_n = 1'b0;
		bus_req = '0;
		{sa, sb, ovr_a, ovr_b, mon_flag, fast_a, fast_b, sref, lock} = '0;
		void'($urandom(32'h9e5d64d5));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk(link_cfg.lanes, 32'h2);
		chk(link_cfg.conv, 32'h2);
		chk(link_cfg.octets, 32'h2);
		rdchk(`JOFC_OFS_CB2_SEL, 8'h01);
		rdchk(`JOFC_OFS_SAMPLE_FMT, 8'h01);
		rdchk(`JOFC_OFS_CHAN_ORDER, 8'h00);
		rdchk(`JOFC_OFS_QUICK_PARAM, 8'h49);
		rdchk(16'h0600, 8'h00);
		$display("reset test done");
		wr(`JOFC_OFS_SAMPLE_FMT, 8'hFF);
		rdchk(`JOFC_OFS_SAMPLE_FMT, 8'h07);
		wr(`JOFC_OFS_CHAN_ORDER, 8'hFF);
		rdchk(`JOFC_OFS_CHAN_ORDER, 8'h03);
		wr(`JOFC_OFS_PLL_STATUS, 8'hFF);
		rdchk(`JOFC_OFS_PLL_STATUS, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(`JOFC_OFS_CB2_SEL, 8'(c) | 8'hF8);
			rdchk(`JOFC_OFS_CB2_SEL, 8'(c));
			wr(`JOFC_OFS_CHAN_ORDER, 8'h00);
			repeat (2) step(3'(c), 1'b1, 2'h3, 1'b0);
			wr(`JOFC_OFS_CHAN_ORDER, 8'h01);
			repeat (2) step(3'(c), 1'b1, 2'h3, 1'b1);
		end
		for (int i = 0; i < 8; i++) begin
			wr(`JOFC_OFS_SAMPLE_FMT, {5'h0, i[0], 1'b0, i[1]});
			wr(`JOFC_OFS_CHAN_ORDER, {7'h0, i[2]});
			repeat (4) step(3'h7, i[0], {1'b0, i[1]}, i[2]);
		end
		$display("sample path test done");
		for (int i = 0; i < 4; i++) begin
			wr(`JOFC_OFS_RATE_BAND, {codes[i], 4'hF});
			chk(band, codes[i]);
			rdchk(`JOFC_OFS_RATE_BAND, {codes[i], 4'h0});
		end
		repeat (8) begin
			l = 2'($urandom % 2);
			m = 3'($urandom % 3);
			f = 2'($urandom % 4);
			wr(`JOFC_OFS_QUICK_PARAM, {l, m, 1'b0, f});
			chk(link_cfg.lanes, 32'h1 << l);
			chk(link_cfg.conv, 32'h1 << m);
			chk(link_cfg.octets, 32'h1 << f);
			chk(link_cfg.lanes_log2, l);
			chk(link_cfg.conv_log2, m);
			chk(link_cfg.octets_log2, f);
			rdchk(`JOFC_OFS_QUICK_PARAM, {l, m, 1'b0, f});
		end
		$display("link config test done");
		wr(`JOFC_OFS_IRQ_ENABLE, 8'h03);
		@(posedge sys_clk) lock <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rdchk(`JOFC_OFS_PLL_STATUS, 8'h80);
		rdchk(`JOFC_OFS_IRQ_STATUS, 8'h01);
		chk(irq, 1'b1);
		wr(`JOFC_OFS_IRQ_ENABLE, 8'h02);
		chk(irq, 1'b0);
		wr(`JOFC_OFS_IRQ_CLEAR, 8'h01);
		rdchk(`JOFC_OFS_IRQ_STATUS, 8'h00);
		wr(`JOFC_OFS_RATE_BAND, {`JOFC_BAND_TOP, 4'h0});
		chk(band, `JOFC_BAND_TOP);
		rdchk(`JOFC_OFS_IRQ_STATUS, 8'h04);
		wr(`JOFC_OFS_IRQ_CLEAR, 8'h04);
		rdchk(`JOFC_OFS_IRQ_STATUS, 8'h00);
		@(posedge sys_clk) lock <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 chk(irq, 1'b1);
		rdchk(`JOFC_OFS_IRQ_STATUS, 8'h02);
		wr(`JOFC_OFS_IRQ_CLEAR, 8'h02);
		chk(irq, 1'b0);
		rdchk(`JOFC_OFS_IRQ_CLEAR, 8'h00);
		$display("lock and interrupt test done");
		complete_run();
	end
endmodule
`default_nettype wire
